//--- core/clkgen_defines.svh
// Purpose: Constants for the audio amplifier clock generation block.
// Assumes: System clock mclk_i runs at 10 MHz.
// Notes:   Cycle counts are derived from rates, never typed twice.
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_HZ 10000000
`define FS_MIN_HZ 4000
`define FS_SINGLE_MAX_HZ 50000
`define FS_DOUBLE_MAX_HZ 100000
`define FS_QUAD_MAX_HZ 200000
`define PERIOD_MAX_CYC (`MCLK_HZ / `FS_MIN_HZ)
`define PERIOD_SINGLE_CYC (`MCLK_HZ / `FS_SINGLE_MAX_HZ)
`define PERIOD_DOUBLE_CYC (`MCLK_HZ / `FS_DOUBLE_MAX_HZ)
`define PERIOD_QUAD_CYC (`MCLK_HZ / `FS_QUAD_MAX_HZ)

// ----------------------------------------------------------------
// Master to frame clock ratios, index 0 to 8
// ----------------------------------------------------------------
`define RATIO_NUM 9
`define RATIO_0 64
`define RATIO_1 96
`define RATIO_2 128
`define RATIO_3 192
`define RATIO_4 256
`define RATIO_5 384
`define RATIO_6 512
`define RATIO_7 768
`define RATIO_8 1024
`define RATIO_MIN_OK `RATIO_2
`define RATIO_CNT_MAX 2047
`define ACCEPT_SINGLE 9'h1F0
`define ACCEPT_DOUBLE 9'h07C
`define ACCEPT_QUAD 9'h01C
`define RATIO_TOL_SHIFT 4

// ----------------------------------------------------------------
// Divider exponents and reset values
// ----------------------------------------------------------------
`define SYS_DIV_BASE 4'h0
`define SYNC_DIV_BASE 4'h5
`define DIV_L2_RESET 4'h0
`define RATIO_IDX_RESET 4'h0

`endif

//--- core/clkgen_pkg.sv
// Purpose: Types shared by the clock generation block.
// Assumes: Nothing beyond the defines header.
// Notes:   Binary codes are written out.
package clkgen_pkg;

    typedef enum logic [1:0] {
        SPEED_NONE = 2'b00,
        SPEED_SINGLE = 2'b01,
        SPEED_DOUBLE = 2'b10,
        SPEED_QUAD = 2'b11
    } speed_t;

    typedef enum logic {
        DET_WAIT = 1'b0,
        DET_COUNT = 1'b1
    } det_state_t;

endpackage

//--- core/clk_div.sv
// Purpose: Power-of-two divider of a sampled clock level.
// Assumes: src_i is already synchronised to mclk_i.
// Notes:   A new divide exponent is taken only at a period boundary.
`timescale 1ns/10ps
`include "clkgen_defines.svh"

module clk_div (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic src_i,
    input wire logic [3:0] l2_sel_i,
    output logic clk_o
);

    logic src_prev;
    logic [7:0] cnt;
    logic [3:0] l2;
    logic next_src_prev;
    logic [7:0] next_cnt;
    logic [3:0] next_l2;
    logic next_clk;
    logic rise;
    logic fall;
    logic [7:0] full_m1;
    logic [7:0] half;

    assign rise = src_i & ~src_prev;
    assign fall = ~src_i & src_prev;
    assign full_m1 = 8'((9'h001 << l2) - 9'h001);
    assign half = 8'(9'h001 << (l2 - 4'h1));

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    always_comb begin
        next_src_prev = src_i;
        next_cnt = cnt;
        next_l2 = l2;
        next_clk = clk_o;
        if (rise) begin
            // Boundary-only reload.
            // Switching the exponent only as a high phase starts means
            // no shortened pulse can appear on a divider change.
            if (cnt == full_m1) begin
                next_cnt = 8'h00;
                next_clk = 1'b1;
                next_l2 = l2_sel_i;
            end else begin
                next_cnt = cnt + 8'h01;
                if (cnt + 8'h01 == half) begin
                    next_clk = 1'b0;
                end
            end
        end else if (fall && l2 == 4'h0) begin
            next_clk = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_prev <= 1'b0;
            cnt <= 8'h00;
            l2 <= `DIV_L2_RESET;
            clk_o <= 1'b0;
        end else if (clk_en_i) begin
            src_prev <= next_src_prev;
            cnt <= next_cnt;
            l2 <= next_l2;
            clk_o <= next_clk;
        end
    end

endmodule

//--- core/audio_amp_clock_generation.sv
// Purpose: Clock dividers, oscillator control and audio ratio detect.
// Assumes: Pins are sampled at 10 MHz; input clocks are slower than
//          half that rate, so fast master clocks alias in practice.
// Notes:   No software registers; controls are plain inputs.
`timescale 1ns/10ps
`include "clkgen_defines.svh"

module audio_amp_clock_generation
    import clkgen_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic oscillator_input_i,
    input wire logic audio_master_clock_in_i,
    input wire logic audio_frame_clock_in_i,
    input wire logic [1:0] sys_div_sel_i,
    input wire logic [1:0] sync_div_sel_i,
    input wire logic oscillator_powerdown_bit_i,
    output logic divided_clock_output_o,
    output logic supply_sync_clock_o,
    output logic oscillator_output_o,
    output logic oscillator_enable_o,
    output speed_t speed_mode_o,
    output logic [3:0] ratio_index_o,
    output logic ratio_valid_o,
    output logic ratio_unsupported_o,
    output logic mclk_too_slow_o
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] next_sync_a;
    logic [2:0] next_sync_b;

    assign pin_raw = {audio_frame_clock_in_i, audio_master_clock_in_i,
                      oscillator_input_i};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_sync
            always_comb begin
                next_sync_a[g] = pin_raw[g];
                next_sync_b[g] = sync_a[g];
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else if (clk_en_i) begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    logic osc_s;
    logic mck_s;
    logic fck_s;
    assign osc_s = sync_b[0];
    assign mck_s = sync_b[1];
    assign fck_s = sync_b[2];

    // ----------------------------------------------------------------
    // Oscillator control and dividers
    // ----------------------------------------------------------------
    logic next_osc_out;
    logic next_osc_en;

    always_comb begin
        // Power-down gating.
        // The amplifier stage is cut when the host powers it down.
        next_osc_en = ~oscillator_powerdown_bit_i;
        // Crystal drive.
        // A fundamental or overtone crystal only needs the inversion.
        next_osc_out = next_osc_en & ~osc_s;
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oscillator_enable_o <= 1'b0;
            oscillator_output_o <= 1'b0;
        end else if (clk_en_i) begin
            oscillator_enable_o <= next_osc_en;
            oscillator_output_o <= next_osc_out;
        end
    end

    clk_div u_sys_div (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .clk_en_i(clk_en_i),
        .src_i(osc_s),
        .l2_sel_i(`SYS_DIV_BASE + {2'b00, sys_div_sel_i}),
        .clk_o(divided_clock_output_o)
    );

    clk_div u_sync_div (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .clk_en_i(clk_en_i),
        .src_i(osc_s),
        .l2_sel_i(`SYNC_DIV_BASE + {2'b00, sync_div_sel_i}),
        .clk_o(supply_sync_clock_o)
    );

    // ----------------------------------------------------------------
    // Ratio measurement
    // ----------------------------------------------------------------
    localparam logic [10:0] NOM [`RATIO_NUM] = '{
        11'(`RATIO_0), 11'(`RATIO_1), 11'(`RATIO_2), 11'(`RATIO_3),
        11'(`RATIO_4), 11'(`RATIO_5), 11'(`RATIO_6), 11'(`RATIO_7),
        11'(`RATIO_8)};

    det_state_t state;
    det_state_t next_state;
    logic mck_prev;
    logic fck_prev;
    logic [11:0] per_cnt;
    logic [10:0] rat_cnt;
    logic [11:0] next_per_cnt;
    logic [10:0] next_rat_cnt;
    speed_t next_speed;
    speed_t meas_speed;
    logic [3:0] next_idx;
    logic next_valid;
    logic next_unsup;
    logic next_slow;
    logic [8:0] hit;
    logic [8:0] accept;
    logic mck_rise;
    logic fck_rise;

    assign mck_rise = mck_s & ~mck_prev;
    assign fck_rise = fck_s & ~fck_prev;

    // Ratio matching.
    // A tolerance of one sixteenth absorbs sampling jitter.
    generate
        for (g = 0; g < `RATIO_NUM; g++) begin : gen_hit
            assign hit[g] = (rat_cnt >= NOM[g] - (NOM[g] >> `RATIO_TOL_SHIFT))
                && (rat_cnt <= NOM[g] + (NOM[g] >> `RATIO_TOL_SHIFT));
        end
    endgenerate

    always_comb begin
        // A period beyond the slowest frame rate belongs to no band.
        if (per_cnt > 12'(`PERIOD_MAX_CYC)) begin
            meas_speed = SPEED_NONE;
            accept = 9'h000;
        end else if (per_cnt >= 12'(`PERIOD_SINGLE_CYC)) begin
            meas_speed = SPEED_SINGLE;
            accept = `ACCEPT_SINGLE;
        end else if (per_cnt >= 12'(`PERIOD_DOUBLE_CYC)) begin
            meas_speed = SPEED_DOUBLE;
            accept = `ACCEPT_DOUBLE;
        end else if (per_cnt >= 12'(`PERIOD_QUAD_CYC)) begin
            meas_speed = SPEED_QUAD;
            accept = `ACCEPT_QUAD;
        end else begin
            meas_speed = SPEED_NONE;
            accept = 9'h000;
        end
    end

    always_comb begin
        next_state = state;
        next_per_cnt = per_cnt;
        next_rat_cnt = rat_cnt;
        next_speed = speed_mode_o;
        next_idx = ratio_index_o;
        next_valid = ratio_valid_o;
        next_unsup = ratio_unsupported_o;
        next_slow = mclk_too_slow_o;
        case (state)
            DET_WAIT: begin
                if (fck_rise) begin
                    next_state = DET_COUNT;
                    // Counting from one makes the value seen at the next
                    // frame rise equal to the frame period in cycles.
                    next_per_cnt = 12'h001;
                    next_rat_cnt = 11'h000;
                end
            end
            DET_COUNT: begin
                if (per_cnt < 12'hFFF) begin
                    next_per_cnt = per_cnt + 12'h001;
                end
                if (mck_rise && rat_cnt < 11'(`RATIO_CNT_MAX)) begin
                    next_rat_cnt = rat_cnt + 11'h001;
                end
                if (fck_rise) begin
                    next_per_cnt = 12'h001;
                    next_rat_cnt = 11'h000;
                    next_speed = meas_speed;
                    next_idx = `RATIO_IDX_RESET;
                    for (int i = 0; i < `RATIO_NUM; i++) begin
                        if (hit[i]) begin
                            next_idx = 4'(i);
                        end
                    end
                    next_valid = |(hit & accept);
                    next_unsup = ~|(hit & accept);
                    next_slow = rat_cnt < 11'(`RATIO_MIN_OK);
                end else if (per_cnt > 12'(`PERIOD_MAX_CYC)) begin
                    // Frame clock has stopped: drop the old speed, valid and unsupported flags.
                    next_state = DET_WAIT;
                    next_speed = SPEED_NONE;
                    next_valid = 1'b0;
                    next_unsup = 1'b0;
                end
            end
            default: begin
                next_state = DET_WAIT;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= DET_WAIT;
            mck_prev <= 1'b0;
            fck_prev <= 1'b0;
            per_cnt <= 12'h000;
            rat_cnt <= 11'h000;
            speed_mode_o <= SPEED_NONE;
            ratio_index_o <= `RATIO_IDX_RESET;
            ratio_valid_o <= 1'b0;
            ratio_unsupported_o <= 1'b0;
            mclk_too_slow_o <= 1'b0;
        end else if (clk_en_i) begin
            state <= next_state;
            mck_prev <= mck_s;
            fck_prev <= fck_s;
            per_cnt <= next_per_cnt;
            rat_cnt <= next_rat_cnt;
            speed_mode_o <= next_speed;
            ratio_index_o <= next_idx;
            ratio_valid_o <= next_valid;
            ratio_unsupported_o <= next_unsup;
            mclk_too_slow_o <= next_slow;
        end
    end

endmodule

//--- bench/clkgen_assertions.sv
// Purpose: Port checks for the clock generation block.
// Assumes: The oscillator runs slower than half of mclk_i.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/10ps
module clkgen_assertions
    import clkgen_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic oscillator_input_i,
    input wire logic oscillator_powerdown_bit_i,
    input wire logic supply_sync_clock_o,
    input wire logic oscillator_output_o,
    input wire logic oscillator_enable_o,
    input wire speed_t speed_mode_o,
    input wire logic [3:0] ratio_index_o,
    input wire logic ratio_valid_o,
    input wire logic ratio_unsupported_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Span restarts at every edge of the sync clock, so a glitch
    // shows up as a short span.
    logic [2:0] up;
    logic [5:0] span;
    logic sync_q;
    logic [2:0] next_up;
    logic [5:0] next_span;
    always_comb begin
        next_up = !clk_en_i ? 3'h0 : (up == 3'h7) ? up : up + 3'h1;
        next_span = (supply_sync_clock_o != sync_q) ? 6'h1 :
            (span == 6'h3F) ? span : span + 6'h1;
    end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up <= 3'h0;
            span <= 6'h3F;
            sync_q <= 1'b0;
        end else begin
            up <= next_up;
            span <= next_span;
            sync_q <= supply_sync_clock_o;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    a_enable_follow: assert property (
        up != 3'h0 |-> oscillator_enable_o ==
        !$past(oscillator_powerdown_bit_i)) else $error("enable lag");
    a_osc_quiet: assert property (
        up == 3'h7 && $past(oscillator_powerdown_bit_i) &&
        $past(oscillator_powerdown_bit_i, 2) |-> !oscillator_output_o)
        else $error("oscillator output while off");
    a_osc_invert: assert property (
        up == 3'h7 && !$past(oscillator_powerdown_bit_i) &&
        !$past(oscillator_powerdown_bit_i, 2) &&
        !$past(oscillator_powerdown_bit_i, 3) |->
        oscillator_output_o == !$past(oscillator_input_i, 3))
        else $error("oscillator output wrong");
    a_sync_phase: assert property (
        supply_sync_clock_o != sync_q |-> span >= 6'h1F)
        else $error("short sync phase");
    a_valid_speed: assert property (
        ratio_valid_o |-> speed_mode_o != SPEED_NONE)
        else $error("valid without speed");
    a_valid_unsup: assert property (
        !(ratio_valid_o && ratio_unsupported_o))
        else $error("valid and unsupported");
    a_single_index: assert property (
        ratio_valid_o && speed_mode_o == SPEED_SINGLE |->
        ratio_index_o inside {[4'h4:4'h8]}) else $error("single ratio");
    a_double_index: assert property (
        ratio_valid_o && speed_mode_o == SPEED_DOUBLE |->
        ratio_index_o inside {[4'h2:4'h6]}) else $error("double ratio");
    a_quad_index: assert property (
        ratio_valid_o && speed_mode_o == SPEED_QUAD |->
        ratio_index_o inside {[4'h2:4'h4]}) else $error("quad ratio");
    c_single: cover property (ratio_valid_o && speed_mode_o == SPEED_SINGLE);
    c_double: cover property (speed_mode_o == SPEED_DOUBLE);
    c_quad: cover property (ratio_unsupported_o && speed_mode_o == SPEED_QUAD);
endmodule

//--- bench/audio_source_model.sv
// Purpose: Oscillator, audio master and frame clock sources.
// Assumes: Frame period is given in cycles of 100 ns.
// Notes:   The frame clock stands still while run_i is low.
`timescale 1ns/10ps
module audio_source_model #(
    parameter int OSC_HALF_NS = 400
) (
    input wire logic run_i,
    input wire logic [31:0] frm_cyc_i,
    input wire logic [31:0] ratio_i,
    output logic osc_o,
    output logic mck_o,
    output logic frm_o
);
    // Free running oscillator.
    // Offset keeps its edges away from the sampling edge.
    initial begin
        osc_o = 1'b0;
        #30;
        forever #(OSC_HALF_NS) osc_o = ~osc_o;
    end
    // Master at ratio times frame rate.
    initial begin
        mck_o = 1'b0;
        #7;
        forever #(frm_cyc_i * 50.0 / ratio_i) mck_o = ~mck_o;
    end
    initial begin
        frm_o = 1'b0;
        #13;
        forever begin
            if (run_i) begin
                #(frm_cyc_i * 50) frm_o = ~frm_o;
            end else begin
                #100;
            end
        end
    end
endmodule

//--- bench/audio_amp_clock_generation_tb.sv
// Purpose: Self-checking bench for the clock generation block.
// Assumes: Oscillator period is OSC_CYC cycles of mclk_i.
// Notes:   Master clocks above 5 MHz cannot be sampled here.
`timescale 1ns/10ps
module audio_amp_clock_generation_tb import clkgen_pkg::*;;
    localparam int OSC_CYC = 8;
    int error_cnt = 0;
    int num_checks = 0;
    int rat[9] = '{64, 96, 128, 192, 256, 384, 512, 768, 1024};
    int tp[6] = '{200, 199, 150, 100, 99, 50};
    int tr[6] = '{64, 64, 64, 32, 32, 16};
    logic [31:0] seed = 32'h7282;
    logic [31:0] frm_cyc = 32'h960;
    logic [31:0] ratio = 32'h100;
    logic run = 1'b0;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic oscillator_powerdown_bit_i = 1'b0;
    logic [1:0] sys_div_sel_i = 2'h0;
    logic [1:0] sync_div_sel_i = 2'h0;
    logic oscillator_input_i, audio_master_clock_in_i;
    logic audio_frame_clock_in_i, divided_clock_output_o;
    logic supply_sync_clock_o, oscillator_output_o;
    logic oscillator_enable_o, ratio_valid_o, ratio_unsupported_o;
    logic mclk_too_slow_o;
    logic [3:0] ratio_index_o;
    speed_t speed_mode_o;
    audio_source_model #(.OSC_HALF_NS(OSC_CYC * 50)) src (.run_i(run),
        .frm_cyc_i(frm_cyc), .ratio_i(ratio), .osc_o(oscillator_input_i),
        .mck_o(audio_master_clock_in_i), .frm_o(audio_frame_clock_in_i));
    audio_amp_clock_generation uut (.*);
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(inout int t);
        @(posedge mclk_i);
        #1;
        t++;
    endtask
    // Measures one whole high phase and the low phase after it.
    task automatic phases(input bit w, output int hi, output int lo);
        int t;
        t = 0;
        hi = 0;
        lo = 0;
        while ((w ? supply_sync_clock_o : divided_clock_output_o) !== 1'b0
            && t < 9000) tick(t);
        while ((w ? supply_sync_clock_o : divided_clock_output_o) !== 1'b1
            && t < 9000) tick(t);
        while ((w ? supply_sync_clock_o : divided_clock_output_o) === 1'b1
            && t < 9000) begin
            tick(t);
            hi++;
        end
        while ((w ? supply_sync_clock_o : divided_clock_output_o) === 1'b0
            && t < 9000) begin
            tick(t);
            lo++;
        end
    endtask
    task automatic do_reset();
        @(negedge mclk_i);
        nrst_i = 1'b0;
        repeat (12) @(negedge mclk_i);
        compare("reset outputs", 0, {divided_clock_output_o,
            supply_sync_clock_o, oscillator_output_o, oscillator_enable_o,
            speed_mode_o, ratio_index_o, ratio_valid_o, ratio_unsupported_o,
            mclk_too_slow_o});
        nrst_i = 1'b1;
    endtask
    // The old half frame drains first, then three frames settle the count.
    task automatic detect(input int p, input int r);
        speed_t sp;
        int id;
        logic ok;
        int old;
        @(negedge mclk_i);
        old = frm_cyc;
        frm_cyc = p;
        ratio = r;
        run = 1'b1;
        repeat (old / 2 + 3 * p + 20) @(posedge mclk_i);
        #1;
        sp = (p >= 200 && p <= 2500) ? SPEED_SINGLE : (p >= 100) ?
            SPEED_DOUBLE : (p >= 50) ? SPEED_QUAD : SPEED_NONE;
        id = 0;
        ok = 1'b0;
        foreach (rat[i]) begin
            if (r >= rat[i] - rat[i] / 16 && r <= rat[i] + rat[i] / 16) begin
                id = i;
                ok = 1'b1;
            end
        end
        if (sp == SPEED_SINGLE) ok = ok && id >= 4;
        if (sp == SPEED_DOUBLE) ok = ok && id >= 2 && id <= 6;
        if (sp == SPEED_QUAD) ok = ok && id >= 2 && id <= 4;
        compare("speed", sp, speed_mode_o);
        compare("index", id, ratio_index_o);
        compare("valid", ok, ratio_valid_o);
        compare("unsupported", !ok, ratio_unsupported_o);
        compare("too slow", r < 128, mclk_too_slow_o);
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #10000000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        int hi;
        int lo;
        logic [2:0] frz;
        do_reset();
        for (int s = 0; s < 4; s++) begin
            @(negedge mclk_i);
            sys_div_sel_i = 2'(s);
            sync_div_sel_i = 2'(3 - s);
            repeat (2) phases(1'b0, hi, lo);
            compare("sys high", (1 << s) * OSC_CYC / 2, hi);
            compare("sys low", (1 << s) * OSC_CYC / 2, lo);
            repeat (2) phases(1'b1, hi, lo);
            compare("sync high", (32 << (3 - s)) * OSC_CYC / 2, hi);
            compare("sync low", (32 << (3 - s)) * OSC_CYC / 2, lo);
        end
        @(negedge mclk_i);
        oscillator_powerdown_bit_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        repeat (8) begin
            @(posedge mclk_i);
            #1;
            compare("osc out", 0, oscillator_output_o);
            compare("osc enable", 0, oscillator_enable_o);
        end
        @(negedge mclk_i);
        oscillator_powerdown_bit_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        compare("osc enable", 1, oscillator_enable_o);
        // A low clock enable must hold the divided, sync and oscillator outputs while the pins run.
        @(negedge mclk_i);
        clk_en_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        frz = {divided_clock_output_o, supply_sync_clock_o,
            oscillator_output_o};
        repeat (40) @(posedge mclk_i);
        #1;
        compare("frozen", frz, {divided_clock_output_o, supply_sync_clock_o,
            oscillator_output_o});
        @(negedge mclk_i);
        clk_en_i = 1'b1;
        do_reset();
        for (int k = 4; k < 9; k++) detect(2400, rat[k]);
        repeat (2) begin
            seed = xs(seed);
            detect(600 + int'(seed % 1801), 256);
        end
        foreach (tp[i]) detect(tp[i], tr[i]);
        @(negedge mclk_i);
        run = 1'b0;
        repeat (2700) @(posedge mclk_i);
        #1;
        compare("lost speed", SPEED_NONE, speed_mode_o);
        compare("lost valid", 0, ratio_valid_o);
        compare("lost unsupported", 0, ratio_unsupported_o);
        detect(2400, 384);
        tally_and_finish();
    end
endmodule
bind audio_amp_clock_generation clkgen_assertions chk (.mclk_i, .nrst_i,
    .clk_en_i, .oscillator_input_i, .oscillator_powerdown_bit_i,
    .supply_sync_clock_o, .oscillator_output_o, .oscillator_enable_o,
    .speed_mode_o, .ratio_index_o, .ratio_valid_o, .ratio_unsupported_o);
